// *** rtl/hcrop_pkg.sv ***
// constants, carriers and helpers shared by the horizontal crop stage
package hcrop_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int COL_W = 13;
    localparam int PIX_W = 24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PORTS = 2;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_FIRST_LO = 8'h36;
    localparam logic [ADDR_W-1:0] ADDR_FIRST_HI = 8'h37;
    localparam logic [ADDR_W-1:0] ADDR_LAST_LO = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_LAST_HI = 8'h39;
    localparam logic [ADDR_W-1:0] ADDR_PORT_CTRL = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h41;
    localparam logic [ADDR_W-1:0] ADDR_LEN0_LO = 8'h42;
    localparam logic [ADDR_W-1:0] ADDR_LEN0_HI = 8'h43;
    localparam logic [ADDR_W-1:0] ADDR_LEN1_LO = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_LEN1_HI = 8'h45;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int ENABLE_BIT = 7;
    localparam int LO_BITS = 8;
    localparam int HI_BITS = 5;
    localparam int SEL_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam logic [COL_W-1:0] COL_RESET = 13'h0000;
    localparam logic [COL_W-1:0] COL_ONE = 13'h0001;
    localparam logic [COL_W-1:0] COL_MAX = 13'h1FFF;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [PIX_W-1:0] BLANK_PIXEL = 24'h000000;

    // ------------------------------------------------------------------
    // output modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_SPLITTER = 2'b01,
        MODE_INDEPENDENT = 2'b10,
        MODE_SPARE = 2'b11
    } out_mode_type;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic pixel_valid_strobe;
        logic hsync;
        logic vsync;
        logic [PIX_W-1:0] data;
    } pixel_type;

    typedef struct packed {
        logic enable;
        logic [COL_W-1:0] first;
        logic [COL_W-1:0] last;
    } window_type;

    localparam window_type WINDOW_RESET = '{enable: 1'b0, first: COL_RESET, last: COL_RESET};

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic window_hit(input logic [COL_W-1:0] col, input window_type w);
        window_hit = (col >= w.first) && (col <= w.last);
    endfunction : window_hit

    function automatic logic [DATA_W-1:0] low_byte(input logic [COL_W-1:0] v);
        low_byte = v[LO_BITS-1:0];
    endfunction : low_byte

    function automatic logic [DATA_W-1:0] high_byte(input logic [COL_W-1:0] v);
        high_byte = {3'h0, v[COL_W-1:LO_BITS]};
    endfunction : high_byte

    function automatic logic split_mode(input out_mode_type m);
        split_mode = (m == MODE_SPLITTER) || (m == MODE_INDEPENDENT);
    endfunction : split_mode

endpackage : hcrop_pkg

// *** rtl/hcrop_lane.sv ***
// one output lane: blanks pixels outside the column window
`timescale 1ns/10ps
`default_nettype none
module hcrop_lane
    import hcrop_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // window and position
    input var window_type i_window,
    input wire logic [COL_W-1:0] i_col,
    // video
    input var pixel_type i_pix,
    output var pixel_type o_pix
);

    // ------------------------------------------------------------------
    // gating
    // ------------------------------------------------------------------
    logic keep;

    // disabled: pass everything; enabled: keep first..last inclusive
    assign keep = !i_window.enable || window_hit(i_col, i_window); // RQ3 RQ5 RQ8 RQ10

    // one register stage in both cases so latency never changes with enable
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_pix <= '0;
        end
        else
        begin
            o_pix.hsync <= i_pix.hsync;
            o_pix.vsync <= i_pix.vsync;
            o_pix.pixel_valid_strobe <= i_pix.pixel_valid_strobe && keep; // RQ3 RQ5
            o_pix.data <= keep ? i_pix.data : BLANK_PIXEL; // RQ10
        end
    end

endmodule : hcrop_lane
`default_nettype wire

// *** rtl/hcrop_top.sv ***
// horizontal crop stage with per-port window registers
// How it works
// (RQ1) bit 7 of first-high register enables cropping
// (RQ2) first column: 13 bits, low/high registers
// (RQ3) pixels before first column become blanking
// (RQ4) last column: 13 bits, low/high registers
// (RQ5) last column kept, later pixels blanked
// (RQ6) columns count 0 to line length minus one
// (RQ7) split modes: registers reach selected port only
// (RQ8) window bounds act only while enabled
// (RQ9) reserved high-register bits read zero
// (RQ10) disabled: pass through, same latency
`timescale 1ns/10ps
`default_nettype none
module hcrop_top
    import hcrop_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [DATA_W-1:0] o_reg_rdata,
    // video from the pixel source, one stream per output port
    input var pixel_type i_pix0,
    input var pixel_type i_pix1,
    // video toward the serial link transmitters
    output var pixel_type o_pix0,
    output var pixel_type o_pix1
);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    window_type win_reg [PORTS];
    out_mode_type mode_reg;
    logic sel_reg;
    logic [PORTS-1:0] overrun_reg;
    logic [PORTS-1:0] overrun_next;

    // ------------------------------------------------------------------
    // line measurement state
    // ------------------------------------------------------------------
    logic [COL_W-1:0] col_reg [PORTS];
    logic [COL_W-1:0] len_reg [PORTS];
    logic [PORTS-1:0] valid_d_reg;

    // ------------------------------------------------------------------
    // derived selects
    // ------------------------------------------------------------------
    pixel_type pix_in [PORTS];
    window_type win_use [PORTS];
    logic bank;
    logic wr_any;
    logic [PORTS-1:0] line_end;

    assign pix_in[0] = i_pix0;
    assign pix_in[1] = i_pix1;

    // single mode: one set serves both ports, the select bit is ignored
    assign bank = split_mode(mode_reg) ? sel_reg : 1'b0; // RQ7
    assign win_use[0] = win_reg[0];
    assign win_use[1] = split_mode(mode_reg) ? win_reg[1] : win_reg[0]; // RQ7
    assign wr_any = i_reg_wr;

    always_comb
    begin
        for (int p = 0; p < PORTS; p++)
        begin
            line_end[p] = valid_d_reg[p] && !pix_in[p].pixel_valid_strobe;
        end
    end

    // ------------------------------------------------------------------
    // window register writes
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                win_reg[p] <= WINDOW_RESET;
            end
        end
        else if (wr_any)
        begin
            case (i_reg_addr)
                ADDR_FIRST_LO:
                begin
                    win_reg[bank].first[LO_BITS-1:0] <= i_reg_wdata; // RQ2
                end
                ADDR_FIRST_HI:
                begin
                    win_reg[bank].first[COL_W-1:LO_BITS] <= i_reg_wdata[HI_BITS-1:0]; // RQ2
                    win_reg[bank].enable <= i_reg_wdata[ENABLE_BIT]; // RQ1
                end
                ADDR_LAST_LO:
                begin
                    win_reg[bank].last[LO_BITS-1:0] <= i_reg_wdata; // RQ4
                end
                ADDR_LAST_HI:
                begin
                    win_reg[bank].last[COL_W-1:LO_BITS] <= i_reg_wdata[HI_BITS-1:0]; // RQ4
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // port select and mode
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            sel_reg <= 1'b0;
            mode_reg <= MODE_SINGLE;
        end
        else if (wr_any && (i_reg_addr == ADDR_PORT_CTRL))
        begin
            sel_reg <= i_reg_wdata[SEL_BIT];
            mode_reg <= out_mode_type'(i_reg_wdata[MODE_LSB+1:MODE_LSB]);
        end
    end

    // ------------------------------------------------------------------
    // column counters and line length capture
    // ------------------------------------------------------------------
    // a line is the run of valid pixels; the count restarts once it ends
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            valid_d_reg <= '0;
            for (int p = 0; p < PORTS; p++)
            begin
                col_reg[p] <= COL_RESET;
                len_reg[p] <= COL_RESET;
            end
        end
        else
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                valid_d_reg[p] <= pix_in[p].pixel_valid_strobe;
                if (pix_in[p].pixel_valid_strobe)
                begin
                    // saturate so an overlong line never wraps into the window
                    if (col_reg[p] != COL_MAX)
                    begin
                        col_reg[p] <= col_reg[p] + COL_ONE; // RQ6
                    end
                end
                else if (line_end[p])
                begin
                    col_reg[p] <= COL_RESET; // RQ6
                    len_reg[p] <= col_reg[p];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // window overrun flags
    // ------------------------------------------------------------------
    // set when an enabled window reaches past the line just measured;
    // software clears with a one, and a set in the same cycle wins
    always_comb
    begin
        overrun_next = overrun_reg;
        if (wr_any && (i_reg_addr == ADDR_STATUS))
        begin
            overrun_next = overrun_reg & ~i_reg_wdata[PORTS-1:0];
        end
        for (int p = 0; p < PORTS; p++)
        begin
            if (line_end[p] && win_use[p].enable && (win_use[p].last >= col_reg[p]))
            begin
                overrun_next[p] = 1'b1; // RQ6
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            overrun_reg <= '0;
        end
        else
        begin
            overrun_reg <= overrun_next;
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= BYTE_ZERO;
        end
        else if (i_reg_rd)
        begin
            case (i_reg_addr)
                ADDR_FIRST_LO:
                begin
                    o_reg_rdata <= low_byte(win_reg[bank].first);
                end
                ADDR_FIRST_HI:
                begin
                    // bits 6-5 stay zero
                    o_reg_rdata <= high_byte(win_reg[bank].first) |
                                   (DATA_W'(win_reg[bank].enable) << ENABLE_BIT); // RQ9
                end
                ADDR_LAST_LO:
                begin
                    o_reg_rdata <= low_byte(win_reg[bank].last);
                end
                ADDR_LAST_HI:
                begin
                    o_reg_rdata <= high_byte(win_reg[bank].last); // RQ9
                end
                ADDR_PORT_CTRL:
                begin
                    o_reg_rdata <= {5'h00, mode_reg, sel_reg};
                end
                ADDR_STATUS:
                begin
                    o_reg_rdata <= {6'h00, overrun_reg};
                end
                ADDR_LEN0_LO:
                begin
                    o_reg_rdata <= low_byte(len_reg[0]);
                end
                ADDR_LEN0_HI:
                begin
                    o_reg_rdata <= high_byte(len_reg[0]);
                end
                ADDR_LEN1_LO:
                begin
                    o_reg_rdata <= low_byte(len_reg[1]);
                end
                ADDR_LEN1_HI:
                begin
                    o_reg_rdata <= high_byte(len_reg[1]);
                end
                default:
                begin
                    o_reg_rdata <= BYTE_ZERO;
                end
            endcase
        end
        else
        begin
            // data stand only in the cycle after the read
            o_reg_rdata <= BYTE_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // output lanes
    // ------------------------------------------------------------------
    hcrop_lane u_lane0 (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_window(win_use[0]),
        .i_col(col_reg[0]),
        .i_pix(i_pix0),
        .o_pix(o_pix0)
    );

    hcrop_lane u_lane1 (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_window(win_use[1]),
        .i_col(col_reg[1]),
        .i_pix(i_pix1),
        .o_pix(o_pix1)
    );

endmodule : hcrop_top
`default_nettype wire

// *** verif/hcrop_asserts.sv ***
// port-level assertions for the horizontal crop stage
`timescale 1ns/10ps
`default_nettype none
module hcrop_asserts
    import hcrop_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [DATA_W-1:0] o_reg_rdata,
    // video
    input var pixel_type i_pix0,
    input var pixel_type i_pix1,
    input var pixel_type o_pix0,
    input var pixel_type o_pix1
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_read(a);
        i_reg_rd && i_reg_addr == a ##1 1'b1;
    endsequence
    property p_fwd(pixel_type i, pixel_type o);
        o.pixel_valid_strobe |-> o.data == $past(i.data) && $past(i.pixel_valid_strobe);
    endproperty
    property p_blank(pixel_type i, pixel_type o);
        !$past(i_rst) && $past(i.pixel_valid_strobe) && !o.pixel_valid_strobe |-> o.data == BLANK_PIXEL;
    endproperty
    property p_sync(pixel_type i, pixel_type o);
        !$past(i_rst) |-> o.hsync == $past(i.hsync) && o.vsync == $past(i.vsync);
    endproperty

    a_idle_read_zero: assert property (!$past(i_reg_rd) |-> o_reg_rdata == BYTE_ZERO)
        else $error("read data not zero outside a read");
    a_resv_start: assert property (s_read(ADDR_FIRST_HI) |-> o_reg_rdata[6:5] == 2'h0)
        else $error("reserved start bits not zero");
    a_resv_stop: assert property (s_read(ADDR_LAST_HI) |-> o_reg_rdata[7:5] == 3'h0)
        else $error("reserved stop bits not zero");
    a_unmapped_zero: assert property ($past(i_reg_rd) && !($past(i_reg_addr) inside
        {[ADDR_FIRST_LO:ADDR_LEN1_HI]}) |-> o_reg_rdata == BYTE_ZERO)
        else $error("unmapped read not zero");
    a_reset_clear: assert property ($past(i_rst) |-> o_pix0 == '0 && o_pix1 == '0)
        else $error("outputs not cleared by reset");
    a_fwd_port0: assert property (p_fwd(i_pix0, o_pix0))
        else $error("port 0 forwarded wrong pixel");
    a_fwd_port1: assert property (p_fwd(i_pix1, o_pix1))
        else $error("port 1 forwarded wrong pixel");
    a_blank_port0: assert property (p_blank(i_pix0, o_pix0))
        else $error("port 0 blank carries data");
    a_blank_port1: assert property (p_blank(i_pix1, o_pix1))
        else $error("port 1 blank carries data");
    a_sync_port0: assert property (p_sync(i_pix0, o_pix0))
        else $error("port 0 syncs not passed");
    a_sync_port1: assert property (p_sync(i_pix1, o_pix1))
        else $error("port 1 syncs not passed");
endmodule : hcrop_asserts

bind hcrop_top hcrop_asserts hcrop_asserts_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_pix0(i_pix0), .i_pix1(i_pix1), .o_pix0(o_pix0), .o_pix1(o_pix1));
`default_nettype wire

// *** verif/hcrop_src.sv ***
// pixel source model feeding one input stream of the crop stage
`timescale 1ns/10ps
`default_nettype none
module hcrop_src
    import hcrop_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // line request
    input wire logic i_go,
    input wire logic [COL_W-1:0] i_len,
    input wire logic [PIX_W-1:0] i_seed,
    // stream
    output var pixel_type o_pix,
    output logic o_busy
);
    logic [COL_W-1:0] left_reg;

    assign o_busy = (left_reg != COL_RESET);

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            left_reg <= COL_RESET;
        else if (i_go)
            left_reg <= i_len;
        else if (o_busy)
            left_reg <= left_reg - COL_ONE;
    end

    // idle data toggles so a stale pixel is never mistaken for a fresh one
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            o_pix <= '0;
        else
        begin
            o_pix.pixel_valid_strobe <= o_busy;
            o_pix.hsync <= o_busy && !o_pix.pixel_valid_strobe;
            o_pix.vsync <= i_seed[0];
            o_pix.data <= o_busy ? o_pix.data + i_seed : ~o_pix.data;
        end
    end
endmodule : hcrop_src
`default_nettype wire

// *** verif/hcrop_tb_top.sv ***
// self-checking bench for the horizontal crop stage
`timescale 1ns/10ps
`default_nettype none
module hcrop_tb_top;
    import hcrop_pkg::*;
    typedef struct packed {logic mask; pixel_type pix;} note_type;
    logic i_core_clk, i_rst, i_reg_wr, i_reg_rd, go, busy0, busy1, sel;
    logic [ADDR_W-1:0] i_reg_addr;
    logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata;
    logic [COL_W-1:0] len;
    logic [COL_W-1:0] col [PORTS];
    logic [PIX_W-1:0] seed;
    logic [1:0] mode;
    logic [31:0] lfsr = 32'h00013E8A;
    pixel_type i_pix0, i_pix1, o_pix0, o_pix1;
    window_type win [PORTS];
    note_type pq [PORTS][$];
    logic [DATA_W-1:0] rq [$];
    int fail_count = 0;
    int compares = 0;

    hcrop_top hcrop_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_pix0(i_pix0), .i_pix1(i_pix1), .o_pix0(o_pix0), .o_pix1(o_pix1));
    hcrop_src hcrop_src_inst0 (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_go(go), .i_len(len),
        .i_seed(seed), .o_pix(i_pix0), .o_busy(busy0));
    hcrop_src hcrop_src_inst1 (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_go(go), .i_len(len),
        .i_seed(~seed), .o_pix(i_pix1), .o_busy(busy1));

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        next_rand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next_rand

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_core_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge i_core_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
    endtask : rd

    task automatic set_win(input logic [COL_W-1:0] f, input logic [COL_W-1:0] l, input logic en);
        wr(ADDR_FIRST_LO, f[7:0]);
        wr(ADDR_FIRST_HI, {en, 2'h0, f[12:8]});
        wr(ADDR_LAST_LO, l[7:0]);
        wr(ADDR_LAST_HI, {3'h0, l[12:8]});
        for (int a = 0; a < 4; a++)
            rd(ADDR_FIRST_LO + 8'(a));
    endtask : set_win

    task automatic line(input logic [COL_W-1:0] n, input string name);
        int t;
        @(posedge i_core_clk);
        go <= 1'b1;
        len <= n;
        seed <= lfsr[PIX_W-1:0];
        lfsr = next_rand(lfsr);
        @(posedge i_core_clk);
        go <= 1'b0;
        t = 0;
        do
        begin
            @(posedge i_core_clk);
            #1;
            t++;
        end
        while ((busy0 || busy1) && t < 9000);
        if (t >= 9000)
        begin
            fail_count++;
            tally_and_finish();
        end
        repeat (3) @(posedge i_core_clk);
        $display("test %s done", name);
    endtask : line

    // ------------------------------------------------------------------
    // expectation notes and output watcher
    // ------------------------------------------------------------------
    always @(posedge i_core_clk)
    begin : note
        note_type n;
        pixel_type p;
        window_type w;
        logic [DATA_W-1:0] r;
        logic split;
        logic b;
        split = (mode == MODE_SPLITTER) || (mode == MODE_INDEPENDENT);
        b = split ? sel : 1'b0;
        w = win[b];
        r = BYTE_ZERO;
        if (i_reg_rd)
            case (i_reg_addr)
                ADDR_FIRST_LO: r = w.first[7:0];
                ADDR_FIRST_HI: r = {w.enable, 2'h0, w.first[12:8]};
                ADDR_LAST_LO: r = w.last[7:0];
                ADDR_LAST_HI: r = {3'h0, w.last[12:8]};
                ADDR_PORT_CTRL: r = {5'h00, mode, sel};
                default: r = BYTE_ZERO;
            endcase
        rq.push_back(i_rst ? BYTE_ZERO : r);
        for (int k = 0; k < PORTS; k++)
        begin
            p = (k == 0) ? i_pix0 : i_pix1;
            w = win[split ? k[0] : 1'b0];
            n.mask = w.enable && !p.pixel_valid_strobe;
            n.pix = p;
            if (w.enable && p.pixel_valid_strobe && (col[k] < w.first || col[k] > w.last))
            begin
                n.pix.pixel_valid_strobe = 1'b0;
                n.pix.data = BLANK_PIXEL;
            end
            if (!p.pixel_valid_strobe || i_rst)
                col[k] = COL_RESET;
            else if (col[k] != COL_MAX)
                col[k] = col[k] + COL_ONE;
            pq[k].push_back(i_rst ? '0 : n);
        end
        if (i_rst)
        begin
            win[0] = WINDOW_RESET;
            win[1] = WINDOW_RESET;
            {mode, sel} = 3'h0;
        end
        else if (i_reg_wr)
            case (i_reg_addr)
                ADDR_FIRST_LO: win[b].first[7:0] = i_reg_wdata;
                ADDR_FIRST_HI: {win[b].enable, win[b].first[12:8]} = {i_reg_wdata[7], i_reg_wdata[4:0]};
                ADDR_LAST_LO: win[b].last[7:0] = i_reg_wdata;
                ADDR_LAST_HI: win[b].last[12:8] = i_reg_wdata[4:0];
                ADDR_PORT_CTRL: {mode, sel} = i_reg_wdata[2:0];
                default: ;
            endcase
    end

    always @(negedge i_core_clk)
    begin : watch
        note_type n;
        pixel_type got;
        if (rq.size() > 0)
            check(32'(o_reg_rdata), 32'(rq.pop_front()));
        for (int k = 0; k < PORTS; k++)
            if (pq[k].size() > 0)
            begin
                n = pq[k].pop_front();
                got = (k == 0) ? o_pix0 : o_pix1;
                if (n.mask)
                    got.data = n.pix.data;
                check(32'(got), 32'(n.pix));
            end
    end

    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    initial
    begin
        {i_rst, i_reg_wr, i_reg_rd, go} = 4'hF;
        {i_reg_wr, i_reg_rd, go, i_reg_addr, i_reg_wdata, len, seed} = '0;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        for (int a = 0; a < 4; a++)
            rd(ADDR_FIRST_LO + 8'(a));
        rd(8'h50);
        wr(ADDR_FIRST_HI, 8'hFF);
        wr(ADDR_LAST_HI, 8'hFF);
        rd(ADDR_FIRST_HI);
        rd(ADDR_LAST_HI);
        $display("test registers done");
        set_win(13'h0003, 13'h0004, 1'b0);
        line(13'h000A, "disabled");
        set_win(13'h0001, 13'h0002, 1'b1);
        line(13'h0006, "inner window");
        set_win(13'h0000, 13'h0009, 1'b1);
        line(13'h000A, "full line");
        set_win(13'h0009, 13'h0009, 1'b1);
        line(13'h000A, "last column");
        set_win(13'h0102, 13'h0105, 1'b1);
        line(13'h0110, "wide columns");
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_PORT_CTRL, {5'h00, m[1:0], 1'b1});
            set_win(13'h0002, 13'h0003, 1'b1);
            wr(ADDR_PORT_CTRL, {5'h00, m[1:0], 1'b0});
            set_win(13'h0005, 13'h0006, 1'b1);
            line(13'h0009, "port banks");
        end
        for (int i = 0; i < 24; i++)
        begin
            lfsr = next_rand(lfsr);
            wr(ADDR_PORT_CTRL, {5'h00, lfsr[2:0]});
            rd(ADDR_PORT_CTRL);
            set_win({7'h00, lfsr[13:8]}, {7'h00, lfsr[13:8]} + {7'h00, lfsr[21:16]}, lfsr[31]);
            line(13'h0080, "random");
        end
        tally_and_finish();
    end
endmodule : hcrop_tb_top
`default_nettype wire
